// ==== hdl/bit_sync.sv ====
// Two-stage synchroniser for inputs from outside the pclk domain
`timescale 1ns/100ps
module bit_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q <= '0;
      end else if (ce) begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // bit_sync

// ==== hdl/jtag_pkg.sv ====
// Shared constants, state codes and carrier types of the JTAG test data registers
package jtag_pkg;

   // ************************************************
   // Instruction register layout
   // ************************************************
   localparam int IR_W = 16;
   localparam int CODE_W = 4;
   localparam int CODE_HI = 15;
   localparam int CODE_LO = 12;
   localparam logic [11:0] IR_RSVD = 12'hfff;
   localparam logic [15:0] IR_RST = 16'hffff;

   // Instruction codes
   localparam logic [3:0] C_EXTEST = 4'h0;
   localparam logic [3:0] C_WAKE = 4'h1;
   localparam logic [3:0] C_SAMPLE = 4'h4;
   localparam logic [3:0] C_RST_OFF = 4'h6;
   localparam logic [3:0] C_RST_ON = 4'h7;
   localparam logic [3:0] C_IRQ = 4'ha;
   localparam logic [3:0] C_IRQ_MASK = 4'he;
   localparam logic [3:0] C_BYPASS = 4'hf;

   // ************************************************
   // Boundary chain layout
   // ************************************************
   localparam int BSR_LEN = 298;
   localparam int DOUT_HI = 265;
   localparam int DOUT_LO = 234;
   localparam int DCTL_HI = 233;
   localparam int DCTL_LO = 202;

   // ************************************************
   // APB register map
   // ************************************************
   localparam logic [7:0] OFF_INSTR = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_IRQ_EN = 8'h08;
   localparam logic [7:0] OFF_IRQ_CLR = 8'h0c;
   localparam int EV_W = 3;
   localparam int EV_IRQ = 0;
   localparam int EV_WAKE = 1;
   localparam int EV_RST = 2;
   localparam int LVL_RST = 3;

   // ************************************************
   // TAP states
   // ************************************************
   typedef enum logic [15:0] {
      ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
      ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080,
      ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
      ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UPD_IR = 16'h8000
   } tap_state_e;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } jtag_pins_s;

   // Boundary chain sits between tdi and tdo
   function automatic logic sel_bsr(input logic [3:0] c);
      return (c == C_EXTEST) || (c == C_SAMPLE);
   endfunction

   // Lowest code bit ignored
   function automatic logic is_irq(input logic [3:0] c);
      return (c & C_IRQ_MASK) == C_IRQ;
   endfunction

endpackage

// ==== hdl/jtag_test_data_registers.sv ====
// JTAG bypass, instruction and boundary scan registers with APB status access
//
// Summary of operation
// - Bypass stage is one flip-flop, invisible to the CPU bus.
// - Bypass code routes tdi through the bypass stage to tdo.
// - Instruction register is 16 bits and read-only from the CPU.
// - Test reset or Test-Logic-Reset loads bypass code 1111.
// - Instructions load over the serial port whatever the CPU mode.
// - Code sits in bits 15:12; CPU writes cannot change it.
// - Codes 0000 and 0100 put the boundary chain between tdi and tdo.
// - Code 0111 asserts the debug reset, 0110 releases it.
// - Codes 101X raise a debug interrupt request to the CPU.
// - Code 0001 requests wake-up from sleep.
// - Instruction bits 11:0 always read as one.
// - Boundary cells capture pin inputs and drive pin outputs and enables.
// - Chain enters at cell 297 and shifts toward cell 0.
// - Data pins use input 297-266, output 265-234, control 233-202.
// - Low test reset resets the port without a tck edge.
// - tms, tdi and tdo move in step with tck per standard TAP.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
module jtag_test_data_registers (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_r,
   output logic pready_r,
   output logic pslverr_r,
   // Test port pins
   input wire jtag_pkg::jtag_pins_s jtag_pins,
   output logic tdo_r,
   output logic tdo_oe_r,
   // Pads
   input wire logic [jtag_pkg::BSR_LEN-1:0] pad_in,
   output logic [jtag_pkg::BSR_LEN-1:0] bsr_upd_r,
   output logic extest_r,
   // Toward the chip
   output logic dbg_reset_r,
   output logic wake_req_r,
   output logic irq_r
);
   // ************************************************
   // Pin sampling and tck edges
   // ************************************************
   logic [3:0] pins_q;
   jtag_pkg::jtag_pins_s pins_s;
   logic [jtag_pkg::BSR_LEN-1:0] pad_s;
   logic tck_d_r;
   logic rise;
   logic fall;
   jtag_pkg::tap_state_e tap_st;

   bit_sync #(.W(4)) u_jsync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .d(jtag_pins),
      .q(pins_q)
   );

   bit_sync #(.W(jtag_pkg::BSR_LEN)) u_psync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .d(pad_in),
      .q(pad_s)
   );

   assign pins_s = jtag_pkg::jtag_pins_s'(pins_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tck_d_r <= 1'b0;
      end else if (ce) begin
         tck_d_r <= pins_s.tck;
      end
   end

   assign rise = ce & pins_s.trst_n & pins_s.tck & ~tck_d_r;
   assign fall = ce & pins_s.trst_n & ~pins_s.tck & tck_d_r;

   tap_fsm u_tap (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .step(rise),
      .tms(pins_s.tms),
      .trst_n(pins_s.trst_n),
      .state_r(tap_st)
   );

   // ************************************************
   // Instruction register
   // ************************************************
   logic [jtag_pkg::IR_W-1:0] ir_sh_r;
   logic [jtag_pkg::CODE_W-1:0] code_r;
   logic [jtag_pkg::CODE_W-1:0] new_code;
   logic upd_ir;

   assign new_code = ir_sh_r[jtag_pkg::CODE_HI:jtag_pkg::CODE_LO];
   // No CPU mode or sleep input gates this, so loads work in any mode
   assign upd_ir = rise && (tap_st == jtag_pkg::ST_UPD_IR);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir_sh_r <= jtag_pkg::IR_RST;
      end else if (ce) begin
         if (!pins_s.trst_n) begin
            ir_sh_r <= jtag_pkg::IR_RST;
         end else if (rise && tap_st == jtag_pkg::ST_CAP_IR) begin
            ir_sh_r <= {code_r, jtag_pkg::IR_RSVD};
         end else if (rise && tap_st == jtag_pkg::ST_SH_IR) begin
            ir_sh_r <= {pins_s.tdi, ir_sh_r[jtag_pkg::IR_W-1:1]};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_r <= jtag_pkg::C_BYPASS;
      end else if (ce) begin
         if (!pins_s.trst_n || tap_st == jtag_pkg::ST_TLR) begin
            code_r <= jtag_pkg::C_BYPASS;
         end else if (upd_ir) begin
            code_r <= new_code;
         end
      end
   end

   // ************************************************
   // Commands toward the chip
   // ************************************************
   logic [jtag_pkg::EV_W-1:0] ev_set;

   always_comb begin
      ev_set = '0;
      ev_set[jtag_pkg::EV_IRQ] = upd_ir && jtag_pkg::is_irq(new_code);
      ev_set[jtag_pkg::EV_WAKE] = upd_ir && (new_code == jtag_pkg::C_WAKE);
      ev_set[jtag_pkg::EV_RST] = upd_ir && (new_code == jtag_pkg::C_RST_ON);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbg_reset_r <= 1'b0;
      end else if (ce) begin
         if (!pins_s.trst_n) begin
            dbg_reset_r <= 1'b0;
         end else if (upd_ir && new_code == jtag_pkg::C_RST_ON) begin
            dbg_reset_r <= 1'b1;
         end else if (upd_ir && new_code == jtag_pkg::C_RST_OFF) begin
            dbg_reset_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_req_r <= 1'b0;
      end else if (ce) begin
         wake_req_r <= ev_set[jtag_pkg::EV_WAKE];
      end
   end

   // ************************************************
   // Bypass stage and boundary chain
   // ************************************************
   logic bypass_r;
   logic [jtag_pkg::BSR_LEN-1:0] bsr_sh_r;
   logic use_bsr;

   // Reserved codes fall into the bypass path; no better answer is owed
   assign use_bsr = jtag_pkg::sel_bsr(code_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bypass_r <= 1'b0;
      end else if (ce && rise) begin
         if (tap_st == jtag_pkg::ST_CAP_DR) begin
            bypass_r <= 1'b0;
         end else if (tap_st == jtag_pkg::ST_SH_DR && !use_bsr) begin
            bypass_r <= pins_s.tdi;
         end
      end
   end

   // Every cell captures its pad, then the chain shifts from cell 297 down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bsr_sh_r <= '0;
      end else if (ce && rise && use_bsr) begin
         if (tap_st == jtag_pkg::ST_CAP_DR) begin
            bsr_sh_r <= pad_s;
         end else if (tap_st == jtag_pkg::ST_SH_DR) begin
            bsr_sh_r <= {pins_s.tdi, bsr_sh_r[jtag_pkg::BSR_LEN-1:1]};
         end
      end
   end

   // Update stage holds pad drive steady while the chain shifts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bsr_upd_r <= '0;
      end else if (ce && rise && use_bsr && tap_st == jtag_pkg::ST_UPD_DR) begin
         bsr_upd_r <= bsr_sh_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         extest_r <= 1'b0;
      end else if (ce) begin
         extest_r <= pins_s.trst_n && (code_r == jtag_pkg::C_EXTEST);
      end
   end

   // ************************************************
   // Serial output, changed on falling tck
   // ************************************************
   logic in_shift;

   assign in_shift = (tap_st == jtag_pkg::ST_SH_DR) || (tap_st == jtag_pkg::ST_SH_IR);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tdo_r <= 1'b0;
         tdo_oe_r <= 1'b0;
      end else if (ce) begin
         if (!pins_s.trst_n) begin
            tdo_oe_r <= 1'b0;
         end else if (fall) begin
            tdo_oe_r <= in_shift;
            if (tap_st == jtag_pkg::ST_SH_IR) begin
               tdo_r <= ir_sh_r[0];
            end else if (use_bsr) begin
               tdo_r <= bsr_sh_r[0];
            end else begin
               tdo_r <= bypass_r;
            end
         end
      end
   end

   // ************************************************
   // APB slave and interrupt status
   // ************************************************
   logic setup;
   logic wr;
   logic [jtag_pkg::EV_W-1:0] irq_en_r;
   logic [jtag_pkg::EV_W-1:0] status_r;
   logic [jtag_pkg::EV_W-1:0] clr;
   logic [31:0] rd_val;
   logic mapped;

   assign setup = ce && psel && !penable;
   assign wr = ce && psel && penable && pready_r && pwrite;
   assign clr = (wr && paddr == jtag_pkg::OFF_IRQ_CLR) ? pwdata[jtag_pkg::EV_W-1:0] : '0;

   always_comb begin
      rd_val = '0;
      mapped = 1'b1;
      case (paddr)
         jtag_pkg::OFF_INSTR: rd_val = {16'h0000, code_r, jtag_pkg::IR_RSVD};
         jtag_pkg::OFF_STATUS: rd_val = {28'h0000000, dbg_reset_r, status_r};
         jtag_pkg::OFF_IRQ_EN: rd_val = {29'h00000000, irq_en_r};
         jtag_pkg::OFF_IRQ_CLR: rd_val = '0;
         default: mapped = 1'b0;
      endcase
   end

   // One wait-free access phase: ready rises right after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else if (ce) begin
         pready_r <= setup;
         pslverr_r <= setup && !mapped;
         if (setup && !pwrite) begin
            prdata_r <= rd_val;
         end
      end
   end

   // Writes to the instruction offset land nowhere
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_r <= '0;
      end else if (wr && paddr == jtag_pkg::OFF_IRQ_EN) begin
         irq_en_r <= pwdata[jtag_pkg::EV_W-1:0];
      end
   end

   // A new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= '0;
      end else if (ce) begin
         status_r <= (status_r & ~clr) | ev_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else if (ce) begin
         irq_r <= |(status_r & irq_en_r);
      end
   end

   // ************************************************
   // Checks
   // ************************************************
   apb_ready_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      setup |=> pready_r ##1 (!pready_r || !ce || (psel && !penable)))
      else $error("APB ready not given one cycle after setup");

   instr_ones_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == jtag_pkg::OFF_INSTR)
      |=> (prdata_r[11:0] == jtag_pkg::IR_RSVD) && !pslverr_r)
      else $error("Instruction read has reserved bits not all one");

   instr_ro_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == jtag_pkg::OFF_INSTR && !upd_ir && pins_s.trst_n
       && tap_st != jtag_pkg::ST_TLR) |=> $stable(code_r))
      else $error("CPU write changed the instruction code");

   bypass_reset_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ce && (!pins_s.trst_n || tap_st == jtag_pkg::ST_TLR)) |=> code_r == jtag_pkg::C_BYPASS)
      else $error("Instruction code not bypass after test reset");

   dbg_reset_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (upd_ir && new_code == jtag_pkg::C_RST_ON) |=> dbg_reset_r ##1 (dbg_reset_r || !ce
       || !pins_s.trst_n || $past(upd_ir)))
      else $error("Debug reset not asserted by reset-assert code");

   irq_event_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (upd_ir && jtag_pkg::is_irq(new_code) && irq_en_r[jtag_pkg::EV_IRQ]) |=> ##1 irq_r)
      else $error("Interrupt code did not raise the interrupt");

   wake_pulse_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (upd_ir && new_code == jtag_pkg::C_WAKE) |=> wake_req_r && status_r[jtag_pkg::EV_WAKE])
      else $error("Wake code did not issue a wake request");

   bypass_path_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rise && tap_st == jtag_pkg::ST_SH_DR && !use_bsr) |=> bypass_r == $past(pins_s.tdi))
      else $error("Bypass stage did not take tdi");

   tdo_enable_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (fall && tap_st == jtag_pkg::ST_SH_IR) |=> tdo_oe_r && tdo_r == $past(ir_sh_r[0]))
      else $error("tdo not driven from instruction LSB in Shift-IR");

endmodule // jtag_test_data_registers

// ==== hdl/tap_fsm.sv ====
// TAP controller state machine stepped by sampled tck rising edges
`timescale 1ns/100ps
module tap_fsm (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Link
   input wire logic step,
   input wire logic tms,
   input wire logic trst_n,
   // State
   output jtag_pkg::tap_state_e state_r
);
   jtag_pkg::tap_state_e state_nxt;

   always_comb begin
      case (state_r)
         jtag_pkg::ST_TLR: state_nxt = tms ? jtag_pkg::ST_TLR : jtag_pkg::ST_RTI;
         jtag_pkg::ST_RTI: state_nxt = tms ? jtag_pkg::ST_SEL_DR : jtag_pkg::ST_RTI;
         jtag_pkg::ST_SEL_DR: state_nxt = tms ? jtag_pkg::ST_SEL_IR : jtag_pkg::ST_CAP_DR;
         jtag_pkg::ST_CAP_DR: state_nxt = tms ? jtag_pkg::ST_EX1_DR : jtag_pkg::ST_SH_DR;
         jtag_pkg::ST_SH_DR: state_nxt = tms ? jtag_pkg::ST_EX1_DR : jtag_pkg::ST_SH_DR;
         jtag_pkg::ST_EX1_DR: state_nxt = tms ? jtag_pkg::ST_UPD_DR : jtag_pkg::ST_PA_DR;
         jtag_pkg::ST_PA_DR: state_nxt = tms ? jtag_pkg::ST_EX2_DR : jtag_pkg::ST_PA_DR;
         jtag_pkg::ST_EX2_DR: state_nxt = tms ? jtag_pkg::ST_UPD_DR : jtag_pkg::ST_SH_DR;
         jtag_pkg::ST_UPD_DR: state_nxt = tms ? jtag_pkg::ST_SEL_DR : jtag_pkg::ST_RTI;
         jtag_pkg::ST_SEL_IR: state_nxt = tms ? jtag_pkg::ST_TLR : jtag_pkg::ST_CAP_IR;
         jtag_pkg::ST_CAP_IR: state_nxt = tms ? jtag_pkg::ST_EX1_IR : jtag_pkg::ST_SH_IR;
         jtag_pkg::ST_SH_IR: state_nxt = tms ? jtag_pkg::ST_EX1_IR : jtag_pkg::ST_SH_IR;
         jtag_pkg::ST_EX1_IR: state_nxt = tms ? jtag_pkg::ST_UPD_IR : jtag_pkg::ST_PA_IR;
         jtag_pkg::ST_PA_IR: state_nxt = tms ? jtag_pkg::ST_EX2_IR : jtag_pkg::ST_PA_IR;
         jtag_pkg::ST_EX2_IR: state_nxt = tms ? jtag_pkg::ST_UPD_IR : jtag_pkg::ST_SH_IR;
         jtag_pkg::ST_UPD_IR: state_nxt = tms ? jtag_pkg::ST_SEL_DR : jtag_pkg::ST_RTI;
         default: state_nxt = jtag_pkg::ST_TLR;
      endcase
   end

   // Test reset needs no tck edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= jtag_pkg::ST_TLR;
      end else if (ce) begin
         if (!trst_n) begin
            state_r <= jtag_pkg::ST_TLR;
         end else if (step) begin
            state_r <= state_nxt;
         end
      end
   end
endmodule // tap_fsm

// ==== sim/jtag_tester.sv ====
// Test port tester model: drives tck, tms, tdi and trst_n and takes tdo
`timescale 1ns/100ps
module jtag_tester (
   // Pins toward the device
   output jtag_pkg::jtag_pins_s pins,
   // Serial return
   input wire logic tdo
);
   // ************************************************
   // Pin sequencing
   // ************************************************
   localparam time HALF = 24;
   initial begin
      pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b0};
   end
   // tck stands low between frames; tdo is taken just before the rise
   task automatic clk(input logic tms_v, input logic tdi_v, output logic tdo_v);
      pins.tms = tms_v;
      pins.tdi = tdi_v;
      #HALF;
      tdo_v = tdo;
      pins.tck = 1'b1;
      #HALF;
      pins.tck = 1'b0;
   endtask
   task automatic set_trst(input logic v);
      pins.trst_n = v;
   endtask
   task automatic seq(input int n, input logic [31:0] tms_bits);
      logic d;
      for (int i = 0; i < n; i++) begin
         clk(tms_bits[i], 1'b0, d);
      end
   endtask
   // Five ones reach Test-Logic-Reset from anywhere, then idle
   task automatic tap_reset();
      seq(6, 32'h1f);
   endtask
   task automatic shift(input int n, input logic [297:0] din, output logic [297:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         clk(i == n - 1, din[i], dout[i]);
      end
      seq(2, 32'h1);
   endtask
   task automatic load_ir(input logic [3:0] code, output logic [15:0] cap);
      logic [297:0] o;
      // Leading zero leaves Test-Logic-Reset or stays in Run-Test/Idle
      seq(5, 32'h6);
      shift(16, {282'h0, code, 12'hfff}, o);
      cap = o[15:0];
   endtask
   task automatic scan_dr(input int n, input logic [297:0] din, output logic [297:0] dout);
      seq(3, 32'h1);
      shift(n, din, dout);
   endtask
endmodule // jtag_tester

// ==== sim/testbench.sv ====
// Self-checking testbench of the JTAG test data registers
`timescale 1ns/100ps
module testbench;
   // ************************************************
   // Signals and instances
   // ************************************************
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   jtag_pkg::jtag_pins_s jtag_pins;
   logic tdo_r;
   logic tdo_oe_r;
   logic ce = 1'b1;
   logic [297:0] pad_in = '0;
   logic [297:0] bsr_upd_r;
   logic extest_r;
   logic dbg_reset_r;
   logic wake_req_r;
   logic irq_r;
   int error_cnt = 0;
   int total_checks = 0;
   int wake_cnt = 0;
   logic [15:0] cap;
   logic [297:0] o;
   logic [31:0] rd;
   logic err;
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (wake_req_r === 1'b1) begin
         wake_cnt++;
      end
   end
   jtag_test_data_registers dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
      .jtag_pins(jtag_pins), .tdo_r(tdo_r), .tdo_oe_r(tdo_oe_r), .pad_in(pad_in),
      .bsr_upd_r(bsr_upd_r), .extest_r(extest_r), .dbg_reset_r(dbg_reset_r),
      .wake_req_r(wake_req_r), .irq_r(irq_r));
   // Released tdo shows the inverse of its last bit, so a missing enable corrupts data
   jtag_tester tester (.pins(jtag_pins), .tdo(tdo_oe_r ? tdo_r : ~tdo_r));
   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic check(input string what, input logic [297:0] seen, input logic [297:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready_r !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      check("apb ready", n < 20, 1'b1);
      rd = prdata_r;
      err = pslverr_r;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic reg_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, rd, exp);
      check("pslverr", err, 1'b0);
   endtask
   // ************************************************
   // Scenarios
   // ************************************************
   task automatic test_reset();
      reg_chk("instr", jtag_pkg::OFF_INSTR, 32'h0000ffff);
      apb(1'b1, jtag_pkg::OFF_INSTR, 32'h0);
      reg_chk("instr ro", jtag_pkg::OFF_INSTR, 32'h0000ffff);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped err", err, 1'b1);
      check("unmapped data", rd, 32'h0);
      $display("test_reset done");
   endtask
   task automatic test_bypass();
      tester.load_ir(jtag_pkg::C_BYPASS, cap);
      check("capture", cap, 16'hffff);
      check("tdo released", tdo_oe_r, 1'b0);
      tester.scan_dr(8, 298'hb3, o);
      check("bypass out", o[7:0], 8'h66);
      $display("test_bypass done");
   endtask
   task automatic test_codes();
      logic [3:0] codes [5] = '{4'h1, 4'h7, 4'h6, 4'ha, 4'hb};
      logic [3:0] prev;
      logic dbg;
      prev = 4'hf;
      dbg = 1'b0;
      apb(1'b1, jtag_pkg::OFF_IRQ_EN, 32'h1);
      foreach (codes[i]) begin
         tester.load_ir(codes[i], cap);
         dbg = (codes[i] == 4'h7) ? 1'b1 : (codes[i] == 4'h6) ? 1'b0 : dbg;
         check("capture", cap, {prev, 12'hfff});
         apb(1'b1, jtag_pkg::OFF_INSTR, 32'h0);
         reg_chk("instr", jtag_pkg::OFF_INSTR, {16'h0, codes[i], 12'hfff});
         check("dbg reset", dbg_reset_r, dbg);
         check("irq", irq_r, codes[i][3:1] == 3'b101);
         reg_chk("status", jtag_pkg::OFF_STATUS, {dbg, codes[i] == 4'h7, codes[i] == 4'h1,
            codes[i][3:1] == 3'b101});
         apb(1'b1, jtag_pkg::OFF_IRQ_CLR, 32'h7);
         repeat (3) @(posedge pclk);
         check("irq cleared", irq_r, 1'b0);
         prev = codes[i];
      end
      check("wake pulses", wake_cnt, 1);
      apb(1'b1, jtag_pkg::OFF_IRQ_EN, 32'h0);
      tester.load_ir(4'ha, cap);
      check("irq masked", irq_r, 1'b0);
      reg_chk("status masked", jtag_pkg::OFF_STATUS, 32'h1);
      $display("test_codes done");
   endtask
   task automatic test_boundary();
      logic [297:0] p1;
      logic [297:0] p2;
      p1 = {2'b01, {74{4'hc}}};
      p2 = {2'b10, {37{8'h35}}};
      @(posedge pclk);
      pad_in <= p1;
      tester.load_ir(jtag_pkg::C_SAMPLE, cap);
      check("extest off", extest_r, 1'b0);
      tester.scan_dr(298, p2, o);
      check("captured", o, p1);
      check("update", bsr_upd_r, p2);
      check("data out cells", bsr_upd_r[265:234], p2[265:234]);
      check("data ctl cells", bsr_upd_r[233:202], p2[233:202]);
      tester.load_ir(jtag_pkg::C_EXTEST, cap);
      check("extest on", extest_r, 1'b1);
      tester.scan_dr(298, p1, o);
      check("extest capture", o, p1);
      check("extest update", bsr_upd_r, p1);
      $display("test_boundary done");
   endtask
   task automatic test_trst();
      tester.load_ir(jtag_pkg::C_RST_ON, cap);
      check("dbg on", dbg_reset_r, 1'b1);
      tester.set_trst(1'b0);
      @(posedge pclk);
      ce <= 1'b0;
      repeat (6) @(posedge pclk);
      check("dbg frozen", dbg_reset_r, 1'b1);
      ce <= 1'b1;
      repeat (4) @(posedge pclk);
      check("dbg off", dbg_reset_r, 1'b0);
      reg_chk("instr trst", jtag_pkg::OFF_INSTR, 32'h0000ffff);
      tester.set_trst(1'b1);
      repeat (4) @(posedge pclk);
      tester.load_ir(jtag_pkg::C_EXTEST, cap);
      reg_chk("instr ext", jtag_pkg::OFF_INSTR, 32'h00000fff);
      tester.tap_reset();
      reg_chk("instr tlr", jtag_pkg::OFF_INSTR, 32'h0000ffff);
      $display("test_trst done");
   endtask
   // ************************************************
   // Run control
   // ************************************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      tester.set_trst(1'b1);
      repeat (4) @(posedge pclk);
      test_reset();
      test_bypass();
      test_codes();
      test_boundary();
      test_trst();
      complete_run();
   end
   // Whole run takes some 43 us of tck traffic
   initial begin
      #200000;
      error_cnt++;
      complete_run();
   end
endmodule // testbench
